// file: common/irq_accept_defines.vh
// Register offsets, field positions and reset values of the interrupt acceptance block.
`ifndef IRQ_ACCEPT_DEFINES_VH
`define IRQ_ACCEPT_DEFINES_VH

`define ADDR_INTERRUPT_CONTROL 4'h0
`define ADDR_VECTOR_TABLE_BASE 4'h4
`define ADDR_PREVIOUS_CONTEXT 4'h8
`define ADDR_ENTRY_ADDRESS 4'hc

`define CURRENT_CPU_PRIORITY_LSB 0
`define CURRENT_CPU_PRIORITY_MSB 7
`define GIE_BIT 15
`define PENDING_PRIORITY_NUMBER_LSB 16
`define PENDING_PRIORITY_NUMBER_MSB 23

`define PCTX_PREVIOUS_PRIORITY_FIELD_LSB 0
`define PCTX_PREVIOUS_PRIORITY_FIELD_MSB 7
`define PCTX_PIE_BIT 8

`define VSS_BIT 0
`define SHIFT_WIDE 5
`define SHIFT_NARROW 3

`define BASE_RESET 32'h0000_0000
`define PRIO_MAX 8'hff

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: logic/cpu_interrupt_acceptance.v
// CPU-side interrupt acceptance, entry and vectoring with an AXI4-Lite slave.
`timescale 1ns/1ps
`include "irq_accept_defines.vh"

// How it works
// - Vector table base register resets to zero.
// - Software writes the base register; expected before enabling interrupts.
// - Every entry address uses the base register's present content.
// - Wide spacing puts entries eight words apart, independent of source.
// - On entry clear global enable and load current priority with pending.
// - After entry no interrupt is taken until enable or return.
// - Return from exception restores the saved global enable.
// - Requests at or below current priority stay blocked.
// - Requests strictly above current priority are taken when enabled and ENTRY_READY_IN is high.
// - Current priority 255 blocks every request.
// - A lowered re-pended request waits until current priority drops below.
// - The entry is chosen only by the serviced priority number.
// - Entry is base with bit 0 cleared ORed with pending shifted 5 or 3.
// - Entry saves old enable and old priority into previous context.
// - Control register: priority 7:0, enable 15, pending 23:16 read-only.
module cpu_interrupt_acceptance (
    input wire CLK_IN,
    input wire RST_IN,
    input wire [7:0] PENDING_PRIORITY_IN,
    input wire ENTRY_READY_IN,
    input wire RETURN_FROM_EXCEPTION_IN,
    output reg TAKE_OUT,
    output reg [7:0] TAKE_PRIORITY_OUT,
    output reg [31:0] ENTRY_ADDRESS_OUT,
    output reg GLOBAL_IRQ_ENABLE_OUT,
    output reg [7:0] CURRENT_CPU_PRIORITY_OUT,
    input wire [3:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [3:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // The pending number and the core's strobes come from other logic on
    // the same clock, so they are used directly without synchronisers.
    // Feeding any of them from a pin or another clock would need two
    // flip-flops in front, and the extra cycles would delay every take.
    // The arbitration unit must also hold the pending number steady for
    // the whole cycle in which it is compared, which a registered source
    // gives for free.

    // ****************************************************************
    // Architectural state
    // ****************************************************************
    reg [31:0] vector_table_base_reg;
    reg global_irq_enable_reg;
    reg [7:0] current_cpu_priority_reg;
    reg previous_enable_field_reg;
    reg [7:0] previous_priority_field_reg;
    reg [31:0] entry_address_reg;
    // The base register keeps bit 0 as the spacing select; the entry
    // computation masks it out of the address.

    // Write channel capture.
    reg aw_held_reg;
    reg [3:0] aw_addr_reg;
    reg w_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire aw_take;
    wire w_take;
    wire write_fire;
    wire [3:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire wr_ctrl;
    wire wr_base;
    wire wr_pctx;
    wire wr_ok;
    wire accept;
    wire [31:0] base_aligned;
    wire [31:0] prio_wide;
    wire [31:0] entry_next;
    wire spacing_narrow;
    wire [31:0] offset_wide;
    wire [31:0] offset_narrow;
    wire [31:0] ctrl_view;
    wire [31:0] pctx_view;
    reg [31:0] ctrl_merged;
    reg [31:0] base_merged;
    reg [31:0] pctx_merged;
    reg [31:0] rd_data_next;
    reg [1:0] rd_resp_next;
    integer i;

    assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID & S_AXI_WREADY;
    assign wr_addr = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR;
    assign wr_data = w_held_reg ? w_data_reg : S_AXI_WDATA;
    assign wr_strb = w_held_reg ? w_strb_reg : S_AXI_WSTRB;
    assign write_fire = (aw_held_reg | aw_take) & (w_held_reg | w_take) &
                        ~S_AXI_BVALID;
    assign wr_ctrl = write_fire & (wr_addr == `ADDR_INTERRUPT_CONTROL);
    assign wr_base = write_fire & (wr_addr == `ADDR_VECTOR_TABLE_BASE);
    assign wr_pctx = write_fire & (wr_addr == `ADDR_PREVIOUS_CONTEXT);
    assign wr_ok = wr_ctrl | wr_base | wr_pctx;

    assign ctrl_view = {8'h00, PENDING_PRIORITY_IN, global_irq_enable_reg,
                        7'h00, current_cpu_priority_reg};
    assign pctx_view = {23'h000000, previous_enable_field_reg,
                        previous_priority_field_reg};

    // ****************************************************************
    // Acceptance and vector computation
    // ****************************************************************
    // strict compare
    // follows: no 8-bit number exceeds 255.
    // zero pending never wins against any priority.
    assign accept = global_irq_enable_reg & ENTRY_READY_IN &
                    (PENDING_PRIORITY_IN > current_cpu_priority_reg);
    // no retake
    // After a take the enable is clear, so the compare above cannot fire
    // again until software sets the enable or a return restores it.

    assign base_aligned = {vector_table_base_reg[31:1], 1'b0};
    assign prio_wide = {24'h000000, PENDING_PRIORITY_IN};
    // priority-only entry
    // Only the number being serviced picks the slot; the source of the
    // request plays no part, so handlers may run on into later slots.
    assign spacing_narrow = vector_table_base_reg[`VSS_BIT];
    assign offset_wide = prio_wide << `SHIFT_WIDE;
    assign offset_narrow = prio_wide << `SHIFT_NARROW;
    // The offset is ORed, not added, into the base. Base bits that overlap
    // the shifted number must be left clear by software, or entries of
    // different numbers would alias onto one address.
    assign entry_next = spacing_narrow ?
                        (base_aligned | offset_narrow) :
                        (base_aligned | offset_wide);

    // Byte-lane merge of write data.
    always @* begin
        ctrl_merged = ctrl_view;
        base_merged = vector_table_base_reg;
        pctx_merged = pctx_view;
        for (i = 0; i < 4; i = i + 1) begin
            if (wr_strb[i]) begin
                ctrl_merged[i*8 +: 8] = wr_data[i*8 +: 8];
                base_merged[i*8 +: 8] = wr_data[i*8 +: 8];
                pctx_merged[i*8 +: 8] = wr_data[i*8 +: 8];
            end
        end
    end

    // ****************************************************************
    // State update
    // ****************************************************************
    // Only one level of previous context is held here. A handler that
    // re-enables interrupts and allows nesting must save the previous
    // context register itself before doing so, and put it back before
    // its return, or the outer return restores the wrong enable.
    // Entry wins over a same-cycle control or previous context write, so a taken interrupt
    // is never half applied; that write is acknowledged but lost.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            vector_table_base_reg <= `BASE_RESET;
            global_irq_enable_reg <= 1'b0;
            current_cpu_priority_reg <= 8'h00;
            previous_enable_field_reg <= 1'b0;
            previous_priority_field_reg <= 8'h00;
            entry_address_reg <= `BASE_RESET;
        end else begin
            // A base write is honoured even in a take cycle; it only moves
            // the entries of later takes.
            // base write
            if (wr_base) begin
                vector_table_base_reg <= base_merged;
            end
            if (accept) begin
                global_irq_enable_reg <= 1'b0;
                current_cpu_priority_reg <= PENDING_PRIORITY_IN;
                previous_enable_field_reg <= global_irq_enable_reg;
                previous_priority_field_reg <= current_cpu_priority_reg;
                entry_address_reg <= entry_next;
            end else if (RETURN_FROM_EXCEPTION_IN) begin
                global_irq_enable_reg <= previous_enable_field_reg;
                current_cpu_priority_reg <= previous_priority_field_reg;
            end else begin
                if (wr_ctrl) begin
                    global_irq_enable_reg <= ctrl_merged[`GIE_BIT];
                    current_cpu_priority_reg <=
                        ctrl_merged[`CURRENT_CPU_PRIORITY_MSB:`CURRENT_CPU_PRIORITY_LSB];
                end
                if (wr_pctx) begin
                    previous_enable_field_reg <= pctx_merged[`PCTX_PIE_BIT];
                    previous_priority_field_reg <=
                        pctx_merged[`PCTX_PREVIOUS_PRIORITY_FIELD_MSB:`PCTX_PREVIOUS_PRIORITY_FIELD_LSB];
                end
            end
        end
    end

    // ****************************************************************
    // Core-facing outputs
    // ****************************************************************
    // The mirrors repeat the next-state choice of the state block, so the
    // outputs come straight from flip-flops yet show the same value as the
    // internal bits in every cycle.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            TAKE_OUT <= 1'b0;
            TAKE_PRIORITY_OUT <= 8'h00;
            ENTRY_ADDRESS_OUT <= `BASE_RESET;
            GLOBAL_IRQ_ENABLE_OUT <= 1'b0;
            CURRENT_CPU_PRIORITY_OUT <= 8'h00;
        end else begin
            TAKE_OUT <= accept;
            if (accept) begin
                TAKE_PRIORITY_OUT <= PENDING_PRIORITY_IN;
                ENTRY_ADDRESS_OUT <= entry_next;
            end
            GLOBAL_IRQ_ENABLE_OUT <= accept ? 1'b0 :
                (RETURN_FROM_EXCEPTION_IN ? previous_enable_field_reg :
                (wr_ctrl ? ctrl_merged[`GIE_BIT] : global_irq_enable_reg));
            CURRENT_CPU_PRIORITY_OUT <= accept ? PENDING_PRIORITY_IN :
                (RETURN_FROM_EXCEPTION_IN ? previous_priority_field_reg :
                (wr_ctrl ? ctrl_merged[`CURRENT_CPU_PRIORITY_MSB:`CURRENT_CPU_PRIORITY_LSB] :
                current_cpu_priority_reg));
        end
    end

    // ****************************************************************
    // AXI4-Lite write channels
    // ****************************************************************
    // Address and data may arrive in either order; each is parked until
    // its partner comes, and one write at most is under way at a time.
    // A write to the read-only entry address register is refused with an
    // error response and changes nothing.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else begin
            if (write_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= S_AXI_AWADDR;
                end
                if (w_take) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= S_AXI_WDATA;
                    w_strb_reg <= S_AXI_WSTRB;
                end
                if (S_AXI_BVALID & S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
            // Each ready only while its own channel holds nothing and no write is answered.
            S_AXI_AWREADY <= ~S_AXI_BVALID & ~write_fire &
                             ~(aw_held_reg | aw_take);
            S_AXI_WREADY <= ~S_AXI_BVALID & ~write_fire &
                            ~(w_held_reg | w_take);
        end
    end

    // ****************************************************************
    // AXI4-Lite read channels
    // ****************************************************************
    // The control word shows the pending number live, so a read returns
    // what the arbitration unit offers in the cycle the address is taken.
    // Unmapped offsets answer with an error and zero data.
    always @* begin
        rd_resp_next = `RESP_OKAY;
        if (S_AXI_ARADDR == `ADDR_INTERRUPT_CONTROL) begin
            rd_data_next = ctrl_view;
        end else if (S_AXI_ARADDR == `ADDR_VECTOR_TABLE_BASE) begin
            rd_data_next = vector_table_base_reg;
        end else if (S_AXI_ARADDR == `ADDR_PREVIOUS_CONTEXT) begin
            rd_data_next = pctx_view;
        end else if (S_AXI_ARADDR == `ADDR_ENTRY_ADDRESS) begin
            rd_data_next = entry_address_reg;
        end else begin
            rd_data_next = 32'h0000_0000;
            rd_resp_next = `RESP_SLVERR;
        end
    end

    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `RESP_OKAY;
        end else begin
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_data_next;
                S_AXI_RRESP <= rd_resp_next;
            end else if (S_AXI_RVALID) begin
                if (S_AXI_RREADY) begin
                    S_AXI_RVALID <= 1'b0;
                end
            end else begin
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

endmodule // cpu_interrupt_acceptance

// file: verification/cpu_interrupt_acceptance_tb.sv
// Self-checking bench of the interrupt acceptance block.
`timescale 1ns/1ps
`include "irq_accept_defines.vh"
module cpu_interrupt_acceptance_tb;
reg clk = 1'h0, rst = 1'h1, ready = 1'h1, ret = 1'h0, awvalid = 1'h0;
reg wvalid = 1'h0, arvalid = 1'h0, en, exp, seen, rdy;
reg [3:0] awaddr = 4'h0, araddr = 4'h0;
reg [31:0] wdata = 32'h0, base, rd;
reg [7:0] req = 8'h00, prio, p;
reg [1:0] resp;
wire [7:0] pend, tprio, cprio;
wire take, gie, awready, wready, bvalid, arready, rvalid;
wire [1:0] bresp, rresp;
wire [31:0] entry, rdata;
integer mismatches = 0, tests_run = 0, seed = 94809, i;
always #50 clk = ~clk;
cpu_interrupt_acceptance i_cpu_interrupt_acceptance (.CLK_IN(clk),
    .RST_IN(rst), .PENDING_PRIORITY_IN(pend), .ENTRY_READY_IN(ready),
    .RETURN_FROM_EXCEPTION_IN(ret), .TAKE_OUT(take), .TAKE_PRIORITY_OUT(tprio),
    .ENTRY_ADDRESS_OUT(entry), .GLOBAL_IRQ_ENABLE_OUT(gie),
    .CURRENT_CPU_PRIORITY_OUT(cprio), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'h1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(1'h1));
irq_arbiter_model i_irq_arbiter_model (.clk_in(clk), .rst_in(rst),
    .request_in(req), .take_in(take), .pending_out(pend));
// ************************************
// Bus cycles, checks and expectations
// ************************************
task chk(input string name, input [31:0] e, input [31:0] g);
    begin
        tests_run = tests_run + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch %0s expected %h seen %h", name, e, g);
        end
    end
endtask
task summarize;
    begin
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
endtask
task wr(input [3:0] a, input [31:0] d);
    reg ta, tw;
    begin
        ta = 1'h0;
        tw = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (awready === 1'h1 && !ta) begin
                ta = 1'h1;
                awvalid <= 1'h0;
            end
            if (wready === 1'h1 && !tw) begin
                tw = 1'h1;
                wvalid <= 1'h0;
            end
        end
        @(posedge clk);
        while (bvalid !== 1'h1) @(posedge clk);
        resp = bresp;
    end
endtask
task rdw(input [3:0] a, output [31:0] d);
    begin
        araddr <= a;
        arvalid <= 1'h1;
        @(posedge clk);
        while (arready !== 1'h1) @(posedge clk);
        arvalid <= 1'h0;
        @(posedge clk);
        while (rvalid !== 1'h1) @(posedge clk);
        d = rdata;
        resp = rresp;
    end
endtask
task wait_take(output s);
    integer n;
    begin
        s = 1'h0;
        for (n = 0; n < 6 && !s; n = n + 1) begin
            @(posedge clk);
            if (take === 1'h1) begin
                s = 1'h1;
                req <= 8'h00;
            end
        end
    end
endtask
function [31:0] entry_of(input [31:0] b, input [7:0] q);
    entry_of = {b[31:1], 1'h0} |
        ({24'h0, q} << (b[0] ? `SHIFT_NARROW : `SHIFT_WIDE));
endfunction
initial begin
    #3000000;
    mismatches = mismatches + 1;
    summarize;
end
initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdw(`ADDR_VECTOR_TABLE_BASE, rd);
    chk("base", `BASE_RESET, rd);
    rdw(4'h2, rd);
    chk("unmapped", `RESP_SLVERR, resp);
    for (i = 0; i < 24; i = i + 1) begin
        base = $random(seed);
        prio = (i == 0) ? `PRIO_MAX : $random(seed);
        p = (i == 1) ? prio : $random(seed);
        en = (i < 2) | $random(seed);
        rdy = (i < 4) | $random(seed);
        ready <= rdy;
        wr(`ADDR_VECTOR_TABLE_BASE, base);
        wr(`ADDR_INTERRUPT_CONTROL, {16'h0, en, 7'h0, prio});
        exp = en && rdy && p > prio;
        req <= p;
        wait_take(seen);
        chk("take", exp, seen);
        if (seen) begin
            chk("entry", entry_of(base, p), entry);
            chk("state", {1'h0, p}, {gie, cprio});
            chk("tprio", p, tprio);
            rdw(`ADDR_ENTRY_ADDRESS, rd);
            chk("entry reg", entry_of(base, p), rd);
            rdw(`ADDR_PREVIOUS_CONTEXT, rd);
            chk("context", {en, prio}, rd);
            req <= prio + 8'h01;
            repeat (3) @(posedge clk);
            rdw(`ADDR_INTERRUPT_CONTROL, rd);
            chk("control", {prio + 8'h01, 8'h00, p}, rd);
            ret <= 1'h1;
            @(posedge clk);
            ret <= 1'h0;
            @(negedge clk);
            chk("restore", {1'h1, prio}, {gie, cprio});
            @(posedge clk);
            wait_take(seen);
            chk("retake", 1'h1, seen);
            chk("repend", entry_of(base, prio + 8'h01), entry);
        end
        if (!seen) req <= 8'h00;
        repeat (3) @(posedge clk);
    end
    summarize;
end
endmodule // cpu_interrupt_acceptance_tb

// file: verification/irq_accept_props.sv
// Assertion checker on the interrupt acceptance ports.
`timescale 1ns/1ps
module irq_accept_props (
    input wire CLK_IN,
    input wire RST_IN,
    input wire [7:0] PENDING_PRIORITY_IN,
    input wire ENTRY_READY_IN,
    input wire TAKE_OUT,
    input wire [7:0] TAKE_PRIORITY_OUT,
    input wire [31:0] ENTRY_ADDRESS_OUT,
    input wire GLOBAL_IRQ_ENABLE_OUT,
    input wire [7:0] CURRENT_CPU_PRIORITY_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_can_take;
        GLOBAL_IRQ_ENABLE_OUT && ENTRY_READY_IN &&
            PENDING_PRIORITY_IN > CURRENT_CPU_PRIORITY_OUT;
    endsequence
    sequence s_take_pulse;
        TAKE_OUT ##1 !TAKE_OUT;
    endsequence
    property p_take_when_able;
        s_can_take |=> TAKE_OUT;
    endproperty
    a_take_when_able: assert property (p_take_when_able)
        else $error("request above priority not taken");
    property p_take_cause;
        TAKE_OUT |-> $past(GLOBAL_IRQ_ENABLE_OUT) && $past(ENTRY_READY_IN)
            && $past(PENDING_PRIORITY_IN) > $past(CURRENT_CPU_PRIORITY_OUT);
    endproperty
    a_take_cause: assert property (p_take_cause)
        else $error("take without a cause");
    property p_take_once;
        TAKE_OUT |-> s_take_pulse;
    endproperty
    a_take_once: assert property (p_take_once)
        else $error("take longer than one cycle");
    property p_disabled;
        !GLOBAL_IRQ_ENABLE_OUT |=> !TAKE_OUT;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("take while disabled");
    property p_entry_state;
        TAKE_OUT |-> !GLOBAL_IRQ_ENABLE_OUT
            && CURRENT_CPU_PRIORITY_OUT == TAKE_PRIORITY_OUT;
    endproperty
    a_entry_state: assert property (p_entry_state)
        else $error("entry state wrong");
    property p_take_prio;
        TAKE_OUT |-> TAKE_PRIORITY_OUT == $past(PENDING_PRIORITY_IN);
    endproperty
    a_take_prio: assert property (p_take_prio)
        else $error("taken priority wrong");
    property p_max_blocks;
        CURRENT_CPU_PRIORITY_OUT == 8'hff |=> !TAKE_OUT;
    endproperty
    a_max_blocks: assert property (p_max_blocks)
        else $error("take at top priority");
    property p_entry_bit0;
        TAKE_OUT |-> ENTRY_ADDRESS_OUT[0] == 1'h0;
    endproperty
    a_entry_bit0: assert property (p_entry_bit0)
        else $error("entry bit 0 set");
endmodule // irq_accept_props
bind cpu_interrupt_acceptance irq_accept_props i_irq_accept_props (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .PENDING_PRIORITY_IN(PENDING_PRIORITY_IN),
    .ENTRY_READY_IN(ENTRY_READY_IN), .TAKE_OUT(TAKE_OUT),
    .TAKE_PRIORITY_OUT(TAKE_PRIORITY_OUT),
    .ENTRY_ADDRESS_OUT(ENTRY_ADDRESS_OUT),
    .GLOBAL_IRQ_ENABLE_OUT(GLOBAL_IRQ_ENABLE_OUT),
    .CURRENT_CPU_PRIORITY_OUT(CURRENT_CPU_PRIORITY_OUT)
);

// file: verification/irq_arbiter_model.sv
// Behavioural model of the arbitration unit feeding pending priority.
`timescale 1ns/1ps
module irq_arbiter_model (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] request_in,
    input wire take_in,
    output reg [7:0] pending_out
);
    // zero between rounds
    // Spanned entry numbers are never handed in, so none is forwarded.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in || take_in) begin
            pending_out <= 8'h00;
        end else begin
            pending_out <= request_in;
        end
    end
endmodule // irq_arbiter_model
